/* File: core/nfc_pkg.sv */
// Shared constants and types for the native FIFO block.
package nfc_pkg;
  localparam int MIN_PORT_WIDTH = 1;
  localparam int MAX_PORT_WIDTH = 1024;
  localparam int MAX_COUNT_WIDTH = 18;
  localparam int MIN_DBIT_ECC_WIDTH = 2;
  localparam int MIN_DEPTH = 2;
  localparam int DEF_DEPTH = 4;
  localparam int DEF_WIDTH = 8;
  localparam int DEF_COUNT_WIDTH = 3;
  localparam int RST_SYNC_STAGES = 2;
  localparam bit DEF_FULL_RST_VAL = 1'b1;
  localparam bit EMPTY_RST_VAL = 1'b1;

  typedef enum logic [1:0] {
    NFC_INJ_NONE,
    NFC_INJ_SINGLE,
    NFC_INJ_DOUBLE,
    NFC_INJ_BOTH
  } nfc_inj_t;

  typedef struct packed {
    logic full;
    logic empty;
    logic valid;
    logic wr_ack;
    logic overflow;
    logic underflow;
  } nfc_flags_t;
endpackage

/* File: core/nfc_fifo_buf.sv */
// Storage FIFO with gray-coded pointers and valid/ready on both sides.
`timescale 1ns/1ns
module nfc_fifo_buf #(
  parameter int WIDTH = nfc_pkg::DEF_WIDTH,
  parameter int DEPTH = nfc_pkg::DEF_DEPTH,
  localparam int AW = $clog2(DEPTH),
  localparam int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk_i, // Clock.
  input wire logic rst_n_i, // Synchronous reset, active low.
  input wire logic in_valid_i, // Word offered.
  output logic in_ready_o, // Space available.
  input wire logic [WIDTH-1:0] in_data_i, // Word to store.
  output logic out_valid_o, // Head word present.
  input wire logic out_ready_i, // Head word taken.
  output logic [WIDTH-1:0] out_data_o, // Head word.
  output logic [CW-1:0] count_o // Words held.
);
  import nfc_pkg::*;

  localparam logic [AW:0] FULL_MASK = (AW + 1)'(3) << (AW - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_bin_ff, rd_bin_ff, wr_gray_ff, rd_gray_ff;
  logic [AW:0] nxt_wr_bin, nxt_rd_bin, nxt_wr_gray, nxt_rd_gray;
  logic [CW-1:0] count_ff, nxt_count;
  logic push, pop;

  // Flags are compared in gray code so that a split-clock build can sample them safely.
  assign in_ready_o = wr_gray_ff != (rd_gray_ff ^ FULL_MASK); // RULE14
  assign out_valid_o = wr_gray_ff != rd_gray_ff; // RULE14
  assign out_data_o = mem[rd_bin_ff[AW-1:0]];
  assign count_o = count_ff;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    nxt_wr_bin = wr_bin_ff + (AW + 1)'(push);
    nxt_rd_bin = rd_bin_ff + (AW + 1)'(pop);
    nxt_wr_gray = nxt_wr_bin ^ (nxt_wr_bin >> 1); // RULE14
    nxt_rd_gray = nxt_rd_bin ^ (nxt_rd_bin >> 1); // RULE14
    nxt_count = count_ff + CW'(push) - CW'(pop);
    if (!rst_n_i) begin
      nxt_wr_bin = '0;
      nxt_rd_bin = '0;
      nxt_wr_gray = '0;
      nxt_rd_gray = '0;
      nxt_count = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    wr_bin_ff <= nxt_wr_bin;
    rd_bin_ff <= nxt_rd_bin;
    wr_gray_ff <= nxt_wr_gray;
    rd_gray_ff <= nxt_rd_gray;
    count_ff <= nxt_count;
  end

  // Storage has no reset; only words behind the write pointer are ever read.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_bin_ff[AW-1:0]] <= in_data_i; // RULE13
    end
  end

  a_gray_one_step: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE14
    $changed(wr_gray_ff) && $past(rst_n_i) |-> $onehot(wr_gray_ff ^ $past(wr_gray_ff)))
    else $error("write pointer gray code moved more than one bit");
  a_depth_legal: assert property (@(posedge clk_i) // RULE13
    DEPTH >= MIN_DEPTH && (DEPTH & (DEPTH - 1)) == 0)
    else $error("depth must be a power of two of at least two");
endmodule // nfc_fifo_buf

/* File: core/nfc_native_fifo.sv */
// Native write/read FIFO with width conversion, status flags and reset handling.
// Notes on behaviour
// RULE1 - A write while full is refused and nothing is stored.
// RULE2 - A read while empty is refused and the output word holds.
// RULE3 - During reset neither writes nor reads are taken.
// RULE4 - The writer drives write enable from this block's clock.
// RULE5 - The reader drives read enable from this block's clock.
// RULE6 - Reset sync on stretches the release internally; off uses the reset directly.
// RULE7 - Fill count output width can be set from 1 to 18 bits.
// RULE8 - Write data width can be set from 1 to 1024 bits.
// RULE9 - Read data width can be set independently from 1 to 1024 bits; the code needs one width to divide the other.
// RULE10 - Double-bit error injection needs both data widths above one bit.
// RULE11 - Output word takes a configured reset value of read width.
// RULE12 - Full flag reset value is configurable as 0 or 1.
// RULE13 - Words leave in write order with no loss or duplication.
// RULE14 - Pointers are gray coded before full and empty are derived; FULL_O and EMPTY_O use the binary fill count, only the storage flags use gray.
`timescale 1ns/1ns
module nfc_native_fifo #(
  parameter int DIN_WIDTH = nfc_pkg::DEF_WIDTH,
  parameter int DOUT_WIDTH = nfc_pkg::DEF_WIDTH,
  parameter int DEPTH = nfc_pkg::DEF_DEPTH,
  parameter int DATA_COUNT_WIDTH = nfc_pkg::DEF_COUNT_WIDTH,
  parameter logic [DOUT_WIDTH-1:0] DOUT_RST_VAL = '0,
  parameter bit FULL_FLAGS_RST_VAL = nfc_pkg::DEF_FULL_RST_VAL,
  parameter bit ENABLE_RST_SYNC = 1'b1,
  parameter bit COMMON_CLOCK = 1'b1,
  parameter nfc_pkg::nfc_inj_t ERROR_INJECTION_TYPE = nfc_pkg::NFC_INJ_NONE
) (
  input wire logic CLK_I, // System clock, 100 MHz.
  input wire logic RST_N_I, // Synchronous reset, active low.
  input wire logic WR_EN_I, // Write request.
  input wire logic [DIN_WIDTH-1:0] DIN_I, // Write word.
  output logic FULL_O, // No room for a write.
  output logic WR_ACK_O, // Previous cycle's write was taken.
  output logic OVERFLOW_O, // Previous cycle's write was refused.
  input wire logic RD_EN_I, // Read request.
  output logic [DOUT_WIDTH-1:0] DOUT_O, // Read word.
  output logic EMPTY_O, // Nothing to read.
  output logic VALID_O, // DOUT_O holds a fresh word.
  output logic UNDERFLOW_O, // Previous cycle's read was refused.
  output logic [DATA_COUNT_WIDTH-1:0] DATA_COUNT_O // Stored words.
);
  import nfc_pkg::*;

  // Storage words are as wide as the wider port, so the wide side always moves whole words.
  // The narrow side steps through lanes; a one-bit lane counter is kept even when it never moves.
  localparam int SW = (DIN_WIDTH > DOUT_WIDTH) ? DIN_WIDTH : DOUT_WIDTH;
  localparam int WR_LANES = SW / DIN_WIDTH;
  localparam int RD_LANES = SW / DOUT_WIDTH;
  localparam int WLW = (WR_LANES > 1) ? $clog2(WR_LANES) : 1;
  localparam int RLW = (RD_LANES > 1) ? $clog2(RD_LANES) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [WLW-1:0] WR_LAST = WLW'(WR_LANES - 1);
  localparam logic [RLW-1:0] RD_LAST = RLW'(RD_LANES - 1);

  // Reset handling.
  logic [RST_SYNC_STAGES-1:0] rst_sync_ff, nxt_rst_sync;
  logic rst_n;

  always_comb begin
    nxt_rst_sync = '0;
    if (RST_N_I) begin
      nxt_rst_sync = {rst_sync_ff[RST_SYNC_STAGES-2:0], 1'b1};
    end
  end

  always_ff @(posedge CLK_I) begin
    rst_sync_ff <= nxt_rst_sync;
  end

  // A release that falls just before an edge still costs two full cycles of idle time.
  // Entry into reset is immediate; only the release is delayed by the chain.
  assign rst_n = ENABLE_RST_SYNC ? (RST_N_I & rst_sync_ff[RST_SYNC_STAGES-1]) : RST_N_I; // RULE6

  // Request acceptance.
  nfc_flags_t flags_ff, nxt_flags;
  logic wr_acc, rd_acc, push, pop;
  logic [WLW-1:0] wlane_ff, nxt_wlane;
  logic [RLW-1:0] rlane_ff, nxt_rlane;
  logic [SW-1:0] pack_ff, nxt_pack, buf_head;
  logic [CW-1:0] buf_count, nxt_cnt;
  logic [DOUT_WIDTH-1:0] dout_ff, nxt_dout, rd_word;
  logic [DATA_COUNT_WIDTH-1:0] dc_ff, nxt_dc, dc_of_cnt;
  logic buf_in_ready, buf_out_valid;

  // A request that misses its edge is simply refused; nothing is queued for a retry.
  // Requests are sampled as-is: the partners drive them from CLK_I.
  assign wr_acc = rst_n & WR_EN_I & ~flags_ff.full; // RULE1 RULE3 RULE4
  assign rd_acc = rst_n & RD_EN_I & ~flags_ff.empty; // RULE2 RULE3 RULE5
  assign push = wr_acc & (wlane_ff == WR_LAST);
  assign pop = rd_acc & (rlane_ff == RD_LAST);
  assign rd_word = buf_head[rlane_ff * DOUT_WIDTH +: DOUT_WIDTH]; // RULE9 RULE13

  // Write side packs narrow words, low lane first, into one storage word.
  always_comb begin
    nxt_pack = pack_ff;
    nxt_wlane = wlane_ff;
    if (wr_acc) begin
      nxt_pack[wlane_ff * DIN_WIDTH +: DIN_WIDTH] = DIN_I; // RULE8 RULE13
      nxt_wlane = (wlane_ff == WR_LAST) ? '0 : wlane_ff + 1'b1;
    end
    if (!rst_n) begin
      nxt_pack = '0;
      nxt_wlane = '0;
    end
  end

  // Read side hands out a wide word one lane at a time, low lane first.
  always_comb begin
    nxt_rlane = rlane_ff;
    nxt_dout = dout_ff;
    if (rd_acc) begin
      nxt_rlane = (rlane_ff == RD_LAST) ? '0 : rlane_ff + 1'b1;
      nxt_dout = rd_word; // RULE13
    end
    if (!rst_n) begin
      nxt_rlane = '0;
      nxt_dout = DOUT_RST_VAL; // RULE11
    end
  end

  // The fill count is at least as wide as needed or narrower; narrower keeps the top bits.
  // A narrow count therefore reads as a coarse fill level and never wraps.
  generate
    if (DATA_COUNT_WIDTH >= CW) begin : g_dc_wide
      assign dc_of_cnt = DATA_COUNT_WIDTH'(nxt_cnt); // RULE7
    end else begin : g_dc_narrow
      assign dc_of_cnt = nxt_cnt[CW-1 -: DATA_COUNT_WIDTH]; // RULE7
    end
  endgenerate

  // Flags are computed one cycle ahead so that they are registered and still exact.
  always_comb begin
    nxt_cnt = buf_count + CW'(push) - CW'(pop);
    nxt_dc = dc_of_cnt;
    nxt_flags.full = nxt_cnt == DEPTH_C; // RULE1
    nxt_flags.empty = nxt_cnt == '0; // RULE2
    nxt_flags.valid = rd_acc;
    nxt_flags.wr_ack = wr_acc;
    // Refusals are not reported in reset, but a partner that keeps asking through reset sees underflow,
    // and overflow if FULL_FLAGS_RST_VAL is 1, on the first edge after release from the reset-valued flags.
    nxt_flags.overflow = rst_n & WR_EN_I & flags_ff.full; // RULE1
    nxt_flags.underflow = rst_n & RD_EN_I & flags_ff.empty; // RULE2
    if (!rst_n) begin
      nxt_dc = '0;
      nxt_flags.full = FULL_FLAGS_RST_VAL; // RULE12
      nxt_flags.empty = EMPTY_RST_VAL;
    end
  end

  always_ff @(posedge CLK_I) begin
    pack_ff <= nxt_pack;
    wlane_ff <= nxt_wlane;
    rlane_ff <= nxt_rlane;
    dout_ff <= nxt_dout;
    dc_ff <= nxt_dc;
    flags_ff <= nxt_flags;
  end

  assign FULL_O = flags_ff.full;
  assign EMPTY_O = flags_ff.empty;
  assign VALID_O = flags_ff.valid;
  assign WR_ACK_O = flags_ff.wr_ack;
  assign OVERFLOW_O = flags_ff.overflow;
  assign UNDERFLOW_O = flags_ff.underflow;
  assign DOUT_O = dout_ff;
  assign DATA_COUNT_O = dc_ff;

  // Passing the last lane through saves a cycle of latency against a second pack stage.
  // The last lane goes straight to storage; earlier lanes come from the pack register.
  logic [SW-1:0] buf_in_data;
  always_comb begin
    buf_in_data = pack_ff;
    buf_in_data[wlane_ff * DIN_WIDTH +: DIN_WIDTH] = DIN_I;
  end

  // The storage sees the internal reset so that its pointers clear together with the flags.
  nfc_fifo_buf #(
    .WIDTH(SW),
    .DEPTH(DEPTH)
  ) u_buf (
    .clk_i(CLK_I),
    .rst_n_i(rst_n),
    .in_valid_i(push),
    .in_ready_o(buf_in_ready),
    .in_data_i(buf_in_data),
    .out_valid_o(buf_out_valid),
    .out_ready_i(pop),
    .out_data_o(buf_head),
    .count_o(buf_count)
  );

  // Checks.
  a_full_refuses: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE1
    WR_EN_I && FULL_O |-> !push ##1 !WR_ACK_O && OVERFLOW_O)
    else $error("write taken while full");
  a_empty_refuses: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE2
    RD_EN_I && EMPTY_O |=> !VALID_O && UNDERFLOW_O && $stable(DOUT_O))
    else $error("read taken while empty");
  a_reset_blocks: assert property (@(posedge CLK_I) // RULE3
    !rst_n |=> !WR_ACK_O && !VALID_O && EMPTY_O && DATA_COUNT_O == '0)
    else $error("access or stale state after reset cycle");
  a_sync_release: assert property (@(posedge CLK_I) // RULE6
    ENABLE_RST_SYNC && $rose(RST_N_I) |-> !rst_n ##1 (!rst_n || !RST_N_I))
    else $error("reset released without synchroniser delay");
  a_sync_legal: assert property (@(posedge CLK_I) // RULE6
    ENABLE_RST_SYNC || !COMMON_CLOCK)
    else $error("unsynchronised reset needs independent clocks");
  a_count_width: assert property (@(posedge CLK_I) // RULE7
    DATA_COUNT_WIDTH >= MIN_PORT_WIDTH && DATA_COUNT_WIDTH <= MAX_COUNT_WIDTH)
    else $error("fill count width out of range");
  a_din_width: assert property (@(posedge CLK_I) // RULE8
    DIN_WIDTH >= MIN_PORT_WIDTH && DIN_WIDTH <= MAX_PORT_WIDTH && SW % DIN_WIDTH == 0)
    else $error("write width out of range or not a lane ratio");
  a_dout_width: assert property (@(posedge CLK_I) // RULE9
    DOUT_WIDTH >= MIN_PORT_WIDTH && DOUT_WIDTH <= MAX_PORT_WIDTH && SW % DOUT_WIDTH == 0)
    else $error("read width out of range or not a lane ratio");
  a_ecc_width: assert property (@(posedge CLK_I) // RULE10
    (ERROR_INJECTION_TYPE != NFC_INJ_DOUBLE && ERROR_INJECTION_TYPE != NFC_INJ_BOTH)
    || (DIN_WIDTH >= MIN_DBIT_ECC_WIDTH && DOUT_WIDTH >= MIN_DBIT_ECC_WIDTH))
    else $error("double-bit injection needs widths above one");
  a_dout_rst_value: assert property (@(posedge CLK_I) // RULE11
    !rst_n ##1 !rst_n |-> DOUT_O == DOUT_RST_VAL)
    else $error("output word lost its reset value");
  a_full_rst_value: assert property (@(posedge CLK_I) // RULE12
    !rst_n |=> FULL_O == FULL_FLAGS_RST_VAL)
    else $error("full flag wrong in reset");
  a_read_delivers: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE13
    rd_acc |=> VALID_O && DOUT_O == $past(rd_word))
    else $error("read word not delivered next cycle");
  a_empty_tracks: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE14
    $past(rst_n) |-> EMPTY_O == (buf_count == '0) && EMPTY_O == !buf_out_valid)
    else $error("empty flag disagrees with stored count");
  a_full_tracks: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE1
    $past(rst_n) |-> FULL_O == !buf_in_ready)
    else $error("full flag disagrees with storage");

  // Each status pulse names one outcome, and only a matching request can cause it.
  a_ack_or_over: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE1
    !(WR_ACK_O && OVERFLOW_O))
    else $error("write both acknowledged and refused");
  a_valid_or_under: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE2
    !(VALID_O && UNDERFLOW_O))
    else $error("read both delivered and refused");
  a_overflow_cause: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE1
    OVERFLOW_O |-> $past(WR_EN_I) && $past(FULL_O))
    else $error("overflow without a refused write");
  a_underflow_cause: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE2
    UNDERFLOW_O |-> $past(RD_EN_I) && $past(EMPTY_O))
    else $error("underflow without a refused read");
  a_ack_cause: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE1
    WR_ACK_O |-> $past(WR_EN_I) && !$past(FULL_O))
    else $error("write acknowledged without room");
  a_valid_cause: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE2
    VALID_O |-> $past(RD_EN_I) && !$past(EMPTY_O))
    else $error("word delivered without a read");
  a_write_taken: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE1
    WR_EN_I && !FULL_O |=> WR_ACK_O && !OVERFLOW_O)
    else $error("write with room not acknowledged");
  a_read_taken: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE2
    RD_EN_I && !EMPTY_O |=> VALID_O && !UNDERFLOW_O)
    else $error("read with data not delivered");
  a_dout_holds: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE2 RULE13
    $past(rst_n) && !VALID_O |-> $stable(DOUT_O))
    else $error("output word changed without a read");

  // Level flags, the fill count and the storage must tell the same story.
  a_not_full_empty: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE1
    $past(rst_n) |-> !(FULL_O && EMPTY_O))
    else $error("full and empty at once");
  a_full_count: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE1
    $past(rst_n) |-> FULL_O == (buf_count == DEPTH_C))
    else $error("full flag disagrees with stored count");
  a_count_bound: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE7
    DATA_COUNT_O <= DEPTH)
    else $error("fill count above depth");
  a_count_empty: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE7
    EMPTY_O |-> DATA_COUNT_O == '0)
    else $error("fill count not zero while empty");
  a_push_has_room: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE1
    push |-> buf_in_ready)
    else $error("storage offered a word it cannot hold");
  a_pop_has_word: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE2
    pop |-> buf_out_valid)
    else $error("storage asked for a word it does not hold");
  a_lane_range: assert property (@(posedge CLK_I) disable iff (!rst_n) // RULE8
    wlane_ff <= WR_LAST && rlane_ff <= RD_LAST)
    else $error("lane counter beyond last lane");

  // Reset drops any partly packed or partly read word and reports no refusals.
  a_reset_quiet: assert property (@(posedge CLK_I) // RULE3
    !rst_n |=> !OVERFLOW_O && !UNDERFLOW_O)
    else $error("refusal reported during reset");
  a_pack_clear: assert property (@(posedge CLK_I) // RULE3
    !rst_n |=> wlane_ff == '0 && rlane_ff == '0)
    else $error("partial word survived reset");

  c_fill_up: cover property (@(posedge CLK_I) disable iff (!rst_n) $rose(FULL_O));
  c_drain: cover property (@(posedge CLK_I) disable iff (!rst_n) $fell(FULL_O) ##[1:20] EMPTY_O);
  c_both: cover property (@(posedge CLK_I) disable iff (!rst_n) wr_acc && rd_acc);
  c_underflow: cover property (@(posedge CLK_I) disable iff (!rst_n) UNDERFLOW_O);
  c_overflow: cover property (@(posedge CLK_I) disable iff (!rst_n) OVERFLOW_O);
endmodule // nfc_native_fifo

/* File: testbench/nfc_user_model.sv */
// Behavioural writer and reader logic that sits on the far side of the native FIFO.
`timescale 1ns/1ns
module nfc_user_model (
  input wire logic clk_i, // Shared clock.
  output logic wr_en_o, // Write request.
  output logic [7:0] din_o, // Write word.
  output logic rd_en_o // Read request.
);
  logic [7:0] last_din;

  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    din_o = 8'h00;
    last_din = 8'h00;
  end

  // Called at a falling edge, so both enables change well clear of the sampling edge.
  task automatic drive(input logic we, input logic [7:0] d, input logic re);
    wr_en_o = we;
    rd_en_o = re;
    // An idle data bus shows the inverse of the last word so a stale value never passes as held.
    if (we) begin
      din_o = d;
      last_din = d;
    end else begin
      din_o = ~last_din;
    end
  endtask
endmodule // nfc_user_model

/* File: testbench/testbench.sv */
// Self-checking testbench for the native FIFO with a queue-based reference.
`timescale 1ns/1ns
module testbench;
  localparam int DEPTH = 4;
  localparam logic [7:0] RST_VAL = 8'h5a;

  logic CLK_I;
  logic RST_N_I;
  logic WR_EN_I;
  logic [7:0] DIN_I;
  logic RD_EN_I;
  logic FULL_O;
  logic WR_ACK_O;
  logic OVERFLOW_O;
  logic [7:0] DOUT_O;
  logic EMPTY_O;
  logic VALID_O;
  logic UNDERFLOW_O;
  logic [2:0] DATA_COUNT_O;
  int errors = 0;
  int compares = 0;
  int hold = 0;
  logic exp_full = 1'b1;
  logic [7:0] exp_dout = RST_VAL;
  logic [7:0] q[$];
  logic full_pk;
  logic ack_pk;
  logic [7:0] dout_pk;
  logic valid_pk;
  logic [2:0] count_pk;

  nfc_native_fifo #(.DEPTH(DEPTH), .DOUT_RST_VAL(RST_VAL)) nfc_native_fifo_inst (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .WR_EN_I(WR_EN_I), .DIN_I(DIN_I), .FULL_O(FULL_O),
    .WR_ACK_O(WR_ACK_O), .OVERFLOW_O(OVERFLOW_O), .RD_EN_I(RD_EN_I), .DOUT_O(DOUT_O),
    .EMPTY_O(EMPTY_O), .VALID_O(VALID_O), .UNDERFLOW_O(UNDERFLOW_O), .DATA_COUNT_O(DATA_COUNT_O));

  nfc_user_model nfc_user_model_inst (.clk_i(CLK_I), .wr_en_o(WR_EN_I), .din_o(DIN_I), .rd_en_o(RD_EN_I));

  // A second build packs two half-width writes into each word and clears its full flag in reset.
  if (1) begin : g_pack
    nfc_native_fifo #(.DIN_WIDTH(4), .DEPTH(DEPTH), .FULL_FLAGS_RST_VAL(1'b0)) nfc_native_fifo_inst (
      .CLK_I(CLK_I), .RST_N_I(RST_N_I), .WR_EN_I(WR_EN_I), .DIN_I(DIN_I[3:0]), .FULL_O(full_pk),
      .WR_ACK_O(ack_pk), .OVERFLOW_O(), .RD_EN_I(RD_EN_I), .DOUT_O(dout_pk), .EMPTY_O(),
      .VALID_O(valid_pk), .UNDERFLOW_O(), .DATA_COUNT_O(count_pk));
  end

  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end

  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One clock of traffic, started at a falling edge; results are judged at the next falling edge.
  task automatic cyc(input logic we, input logic [7:0] d, input logic re);
    logic in_rst;
    logic wacc;
    logic racc;
    in_rst = !RST_N_I || hold > 0;
    wacc = we && !exp_full && !in_rst;
    racc = re && q.size() > 0 && !in_rst;
    nfc_user_model_inst.drive(we, d, re);
    @(negedge CLK_I);
    if (!RST_N_I) begin
      q.delete();
      exp_dout = RST_VAL;
    end
    if (racc) exp_dout = q.pop_front();
    if (wacc) q.push_back(d);
    if (RST_N_I && hold > 0) hold--;
    if (!in_rst) exp_full = (q.size() == DEPTH);
    check(WR_ACK_O, wacc);
    check(OVERFLOW_O, we && !wacc && !in_rst);
    check(VALID_O, racc);
    check(UNDERFLOW_O, re && !racc && !in_rst);
    check(DOUT_O, exp_dout);
    check(FULL_O, exp_full);
    check(EMPTY_O, q.size() == 0);
    check(DATA_COUNT_O, q.size());
  endtask

  // Internal reset releases two edges after the pin, so the model keeps the writer locked out that long.
  task automatic do_reset();
    RST_N_I = 1'b0;
    hold = 2;
    exp_full = 1'b1;
    for (int i = 0; i < 4; i++) begin
      cyc(1'b1, 8'hee, 1'b1);
      check(full_pk, 1'b0);
    end
    RST_N_I = 1'b1;
    for (int i = 0; i < 3; i++) cyc(1'b1, 8'h10, 1'b1);
    // With full low in reset the packing build takes the first write on the third edge after release.
    check(ack_pk, 1'b1);
  endtask

  initial begin
    #20000;
    errors++;
    give_verdict();
  end

  initial begin
    RST_N_I = 1'b0;
    repeat (4) @(negedge CLK_I);
    RST_N_I = 1'b1;
    hold = 2;
    for (int i = 0; i < 3; i++) cyc(1'b1, 8'h10, 1'b1);
    cyc(1'b0, 8'h00, 1'b1);
    for (int i = 0; i < 5; i++) cyc(1'b1, 8'(8'h21 + i), 1'b0);
    cyc(1'b1, 8'h99, 1'b1);
    for (int i = 0; i < 5; i++) cyc(1'b0, 8'h00, 1'b1);
    cyc(1'b1, 8'ha0, 1'b0);
    for (int i = 0; i < 8; i++) cyc(1'b1, 8'(8'hb0 + i), 1'b1);
    cyc(1'b1, 8'hc1, 1'b0);
    cyc(1'b1, 8'hc2, 1'b0);
    do_reset();
    cyc(1'b1, 8'hd5, 1'b0);
    check(count_pk, 3'h1);
    cyc(1'b0, 8'h00, 1'b1);
    check(dout_pk, 8'h50);
    check(valid_pk, 1'b1);
    for (int i = 0; i < 2; i++) cyc(1'b0, 8'h00, 1'b1);
    give_verdict();
  end
endmodule // testbench
